/* verilog/airc_params.svh */
/*
  constants for the interrupt and reset control register: field positions,
  key values, reset values. assumes inclusion by bare name.
*/
`ifndef AIRC_PARAMS_SVH
`define AIRC_PARAMS_SVH
`define AIRC_ADDR_CTRL      4'h0
`define AIRC_KEY_HI         31
`define AIRC_KEY_LO         16
`define AIRC_WRITE_KEY      16'h05FA
`define AIRC_READ_KEY       16'hFA05
`define AIRC_BIT_ENDIAN     15
`define AIRC_BIT_BOOST      14
`define AIRC_BIT_FAULTNS    13
`define AIRC_GROUP_HI       10
`define AIRC_GROUP_LO       8
`define AIRC_BIT_RSTSEC     3
`define AIRC_BIT_RSTREQ     2
`define AIRC_BIT_DBGCLR     1
`define AIRC_GROUP_RESET    3'h0
`endif

/* verilog/airc_pkg.sv */
/*
  types for the interrupt and reset control register block.
  assumes the params header sits on the include path.
*/
package airc_pkg;
  typedef struct packed {
    logic        boost;
    logic        fault_ns;
    logic [2:0]  group;
    logic        rst_sec;
  } airc_ctrl_t;
endpackage

/* verilog/airc_keycheck.sv */
/*
  key comparator: flags a write whose upper half holds the write key.
  assumes write data from the same clock domain.
*/
`timescale 1ns/1ps
`include "airc_params.svh"
module airc_keycheck
  import airc_pkg::*;
(
  input  wire logic [31:0] wdata,
  output wire logic        key_ok
);
  assign key_ok = (wdata[`AIRC_KEY_HI:`AIRC_KEY_LO] == `AIRC_WRITE_KEY);
endmodule

/* verilog/airc_reg.sv */
/*
  application interrupt and reset control register.
  assumes a single-cycle register port on mclk, security state of the
  access given by acc_secure, endianness strap a static level.
*/
// The implementer's own choices: the register addresses and strobed register access.
// Operation
// - writes land only with key 0x5FA in bits 31:16, which read 0xFA05.
// - the key field is one copy for both security states.
// - bit 15 reads the data byte order, read only, not banked.
// - bits 10:8 hold the read-write priority grouping field.
// - bit 1 is debug write-only, reads zero; software writes zero.
// - bit 14 is writable only from secure, reads zero from non-secure.
// - bit 14 at one de-prioritises non-secure exceptions.
// - bit 14 is one copy and enables the priority boost.
// - bit 13 routes bus fault and nmi non-secure, resets to zero; with SECURITY_EXT clear the code reads and drives it as one.
// - writing one to bit 2 requests a system reset; the code raises the request only when SECURITY_EXT is set.
`timescale 1ns/1ps
`include "airc_params.svh"
module airc_reg
  import airc_pkg::*;
#(
  parameter bit SECURITY_EXT = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic        acc_secure,
  input  wire logic        endian_big,
  output logic      [31:0] rdata,
  output logic      [2:0]  priority_grouping_split,
  output logic             secure_priority_boost,
  output logic             fault_nonsecure_routing,
  output logic             system_reset_request
);
  airc_ctrl_t  ctrl_q;
  airc_ctrl_t  ctrl_d;
  logic [31:0] rdata_q;
  logic        rst_pulse_q;
  logic        endian_s1_q;
  logic        endian_s2_q;
  logic        key_ok;
  wire         hit;
  wire         wr_ok;
  wire         sec_w;
  wire         rst_allowed;
  wire [31:0]  rd_word;
  wire         rst_fire;
  wire         rd_hit;
  wire         rd_boost;
  wire         rd_fault_ns;
  wire         rd_rst_sec;

  localparam airc_ctrl_t CTRL_RESET = '{boost: 1'b0, fault_ns: 1'b0,
                                        group: `AIRC_GROUP_RESET, rst_sec: 1'b0};

  airc_keycheck u_key (
    .wdata  (wdata),
    .key_ok (key_ok)
  );

  assign hit = (addr == `AIRC_ADDR_CTRL);
  assign rd_hit = rd_stb && hit;
  assign wr_ok = wr_stb && hit && key_ok;
  assign sec_w = wr_ok && acc_secure && SECURITY_EXT;
  assign rst_allowed = acc_secure || !ctrl_q.rst_sec;
  assign rst_fire = wr_ok && SECURITY_EXT && rst_allowed && wdata[`AIRC_BIT_RSTREQ];
  assign rd_boost = SECURITY_EXT ? (acc_secure & ctrl_q.boost) : 1'b0;
  assign rd_rst_sec = SECURITY_EXT ? (acc_secure & ctrl_q.rst_sec) : 1'b0;
  assign rd_fault_ns = SECURITY_EXT ? ctrl_q.fault_ns : 1'b1;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ok) begin
      ctrl_d.group = wdata[`AIRC_GROUP_HI:`AIRC_GROUP_LO];
    end
    if (sec_w) begin
      ctrl_d.boost    = wdata[`AIRC_BIT_BOOST];
      ctrl_d.fault_ns = wdata[`AIRC_BIT_FAULTNS];
      ctrl_d.rst_sec  = wdata[`AIRC_BIT_RSTSEC];
    end
  end

  // async strap pin: two flops
  always_ff @(posedge mclk) begin
    endian_s1_q <= endian_big;
    endian_s2_q <= endian_s1_q;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rst_pulse_q <= 1'b0;
    end else begin
      rst_pulse_q <= rst_fire;
    end
  end

  // read data stands one cycle, zero otherwise
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd_stb ? rd_word : 32'h0000_0000;
    end
  end

  assign rd_word = !hit ? 32'h0000_0000 :
    {`AIRC_READ_KEY, endian_s2_q, rd_boost, rd_fault_ns,
     2'b00, ctrl_q.group, 4'h0, rd_rst_sec, 1'b0, 1'b0, 1'b0};

  assign rdata = rdata_q;
  assign priority_grouping_split = ctrl_q.group;
  assign secure_priority_boost   = ctrl_q.boost;
  assign fault_nonsecure_routing = SECURITY_EXT ? ctrl_q.fault_ns : 1'b1;
  assign system_reset_request    = rst_pulse_q;

  a_key_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_stb && !key_ok) |=> (ctrl_q == $past(ctrl_q)))
    else $error("keyless write changed state");
  a_group_write: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_ok |=> (priority_grouping_split == $past(wdata[10:8])))
    else $error("grouping not written");
  a_boost_ns_wi: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_stb && !acc_secure) |=> $stable(secure_priority_boost))
    else $error("non-secure changed boost");
  a_read_key: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_stb && hit) |=> (rdata[31:16] == 16'hFA05))
    else $error("key readback wrong");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_stb |=> (rdata[12:11] == 2'b00 && rdata[7:4] == 4'h0 && rdata[1:0] == 2'b00))
    else $error("reserved bits nonzero");
  a_reset_req: assert property (@(posedge mclk) disable iff (!rst_n)
    system_reset_request |-> $past(wr_ok && wdata[2]))
    else $error("spurious reset request");
  a_boost_ns_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_stb && !acc_secure) |=> !rdata[14])
    else $error("boost visible to non-secure");
  a_endian_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_stb && hit) |=> (rdata[15] == $past(endian_s2_q)))
    else $error("byte order bit wrong");

  a_key_bad_word: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_stb && hit && (wdata[`AIRC_KEY_HI:`AIRC_KEY_LO] != `AIRC_WRITE_KEY)) |=>
      $stable(priority_grouping_split))
    else $error("write without key accepted");
  a_key_ns_shared: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_hit && !acc_secure) |=> (rdata[31:16] == `AIRC_READ_KEY))
    else $error("non-secure key readback wrong");
  a_endian_ns: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_hit && !acc_secure) |=> (rdata[15] == $past(endian_s2_q)))
    else $error("byte order not shared");
  a_group_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_ok |=> $stable(priority_grouping_split))
    else $error("grouping changed without write");
  a_debug_bit_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_hit |=> !rdata[`AIRC_BIT_DBGCLR])
    else $error("debug bit read nonzero");

  a_boost_reset: assert property (@(posedge mclk)
    !rst_n |=> !secure_priority_boost)
    else $error("boost not cleared by reset");
  a_boost_sec_write: assert property (@(posedge mclk) disable iff (!rst_n)
    sec_w |=> (secure_priority_boost == $past(wdata[`AIRC_BIT_BOOST])))
    else $error("secure boost write lost");
  a_nosec_layout: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_hit && !SECURITY_EXT) |=> (rdata[14:13] == 2'b01 && rdata[3:2] == 2'b00))
    else $error("layout without security wrong");
  a_nosec_outputs: assert property (@(posedge mclk) disable iff (!rst_n)
    !SECURITY_EXT |-> (fault_nonsecure_routing && !secure_priority_boost &&
      !system_reset_request))
    else $error("security outputs active without security");
  a_unmapped_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_stb && !hit) |=> (rdata == 32'h0000_0000))
    else $error("unmapped read nonzero");
  a_idle_rdata: assert property (@(posedge mclk) disable iff (!rst_n)
    !rd_stb |=> (rdata == 32'h0000_0000))
    else $error("read data outside read cycle");

  a_fault_reset: assert property (@(posedge mclk)
    (!rst_n && SECURITY_EXT) |=> !fault_nonsecure_routing)
    else $error("fault routing not cleared by reset");
  a_fault_ns_wi: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_stb && !acc_secure) |=> $stable(fault_nonsecure_routing))
    else $error("non-secure changed fault routing");
  a_fault_sec_write: assert property (@(posedge mclk) disable iff (!rst_n)
    sec_w |=> (fault_nonsecure_routing == $past(wdata[`AIRC_BIT_FAULTNS])))
    else $error("secure fault routing write lost");
  a_fault_ns_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_hit && SECURITY_EXT) |=> (rdata[13] == $past(fault_nonsecure_routing)))
    else $error("fault routing readback wrong");
  a_reset_fires: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_stb && hit && key_ok && acc_secure && SECURITY_EXT && wdata[2]) |=>
      system_reset_request)
    else $error("secure reset request lost");
  a_reset_refused: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_stb && !acc_secure && ctrl_q.rst_sec) |=> !system_reset_request)
    else $error("non-secure reset not refused");
  a_reset_zero_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_stb && !wdata[2]) |=> !system_reset_request)
    else $error("reset request on zero write");
  a_rstsec_ns_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_stb && !acc_secure) |=> !rdata[3])
    else $error("secure-only reset bit visible");
endmodule

/* bench/tb_app_interrupt_reset_ctrl_reg.sv */
/*
  bench for airc_reg: keyed writes, secure and non-secure access,
  reserved bits, reset request pulse, unmapped index.
  assumes one 20 MHz clock and a static big-endian strap.
*/
`timescale 1ns/1ps
`include "airc_params.svh"
module tb_app_interrupt_reset_ctrl_reg;
  import airc_pkg::*;
  logic        mclk, rst_n, wr_stb, rd_stb, acc_secure, endian_big;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, got;
  logic [2:0]  grp;
  logic        boost, fns, rstreq;
  logic [31:0] rdata_n;
  logic [2:0]  grp_n;
  logic        boost_n, fns_n, rstreq_n;
  int          n_fail, checked;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
  airc_reg DUT (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .acc_secure(acc_secure),
    .endian_big(endian_big), .rdata(rdata), .priority_grouping_split(grp),
    .secure_priority_boost(boost), .fault_nonsecure_routing(fns),
    .system_reset_request(rstreq));
  airc_reg #(.SECURITY_EXT(1'b0)) DUT_NOSEC (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .acc_secure(acc_secure),
    .endian_big(endian_big), .rdata(rdata_n), .priority_grouping_split(grp_n),
    .secure_priority_boost(boost_n), .fault_nonsecure_routing(fns_n),
    .system_reset_request(rstreq_n));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a; wdata <= d; wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    got = rdata;
  endtask
  task automatic t_key();
    `CHK({grp, boost, fns, rstreq}, 6'h00);
    `CHK({grp_n, boost_n, fns_n, rstreq_n}, 6'h02);
    wr(4'h0, 32'h12340700);
    rd(4'h0);
    `CHK(got, 32'hFA058000);
    wr(4'h0, 32'h05FA0700);
    `CHK(grp, 3'h7);
    rd(4'h0);
    `CHK(got, 32'hFA058700);
    wr(4'h1, 32'h05FA0300);
    `CHK(grp, 3'h7);
    rd(4'h1);
    `CHK(got, 32'h00000000);
  endtask
  task automatic t_sec();
    acc_secure <= 1'b1;
    wr(4'h0, 32'h05FA7DF9);
    `CHK({boost, fns, grp}, 5'h1D);
    rd(4'h0);
    `CHK(got, 32'hFA05E508);
  endtask
  task automatic t_ns();
    acc_secure <= 1'b0;
    rd(4'h0);
    `CHK(got, 32'hFA05A500);
    wr(4'h0, 32'h05FA0004);
    `CHK({boost, fns, rstreq, grp}, 6'h30);
    rd(4'h0);
    `CHK(got[31:16], 16'hFA05);
  endtask
  task automatic t_rst();
    acc_secure <= 1'b1;
    wr(4'h0, 32'h05FA0004);
    `CHK(rstreq, 1'b1);
    @(posedge mclk);
    #1;
    `CHK(rstreq, 1'b0);
    rd(4'h0);
    `CHK(got, 32'hFA058000);
    acc_secure <= 1'b0;
    wr(4'h0, 32'h05FA0004);
    `CHK(rstreq, 1'b1);
  endtask
  task automatic t_nosec();
    acc_secure <= 1'b1;
    wr(4'h0, 32'h05FA760C);
    `CHK({boost_n, fns_n, rstreq_n, grp_n}, 6'h16);
    rd(4'h0);
    `CHK(rdata_n, 32'hFA05A600);
  endtask
  task automatic summarize();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    n_fail = 0; checked = 0; rst_n = 1'b0; wr_stb = 1'b0; rd_stb = 1'b0;
    addr = 4'h0; wdata = 32'h0; acc_secure = 1'b0; endian_big = 1'b1;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    t_key();
    t_sec();
    t_ns();
    t_rst();
    t_nosec();
    summarize();
  end
endmodule
